/* dspi_map.svh */
// Constants of the DDR3 pin interface
`ifndef DSPI_MAP_SVH
`define DSPI_MAP_SVH
// Command encodings on row, column and write-enable strobes
`define DSPI_ENC_MRS 3'h0
`define DSPI_ENC_REF 3'h1
`define DSPI_ENC_PRE 3'h2
`define DSPI_ENC_ACT 3'h3
`define DSPI_ENC_WR 3'h4
`define DSPI_ENC_RD 3'h5
`define DSPI_ENC_ZQ 3'h6
`define DSPI_ENC_NOP 3'h7
// Reset and idle values
`define DSPI_CS_IDLE 2'h3
`define DSPI_CKE_RST 1'h0
`define DSPI_ODT_RST 2'h0
`define DSPI_ADDR_RST 16'h0000
`define DSPI_BANK_RST 3'h0
`define DSPI_DQ_RST 16'h0000
`define DSPI_MASK_RST 4'h0
`define DSPI_WORD_RST 32'h0000_0000
// Field positions
`define DSPI_LO 7:0
`define DSPI_HI 15:8
`define DSPI_BEAT0 15:0
`define DSPI_BEAT1 31:16
`define DSPI_MASK0 1:0
`define DSPI_MASK1 3:2
`endif

/* dspi_pkg.sv */
// Types of the DDR3 pin interface
`include "dspi_map.svh"
package dspi_pkg;
   typedef enum logic [2:0] {
      DSPI_CMD_MRS = `DSPI_ENC_MRS,
      DSPI_CMD_REF = `DSPI_ENC_REF,
      DSPI_CMD_PRE = `DSPI_ENC_PRE,
      DSPI_CMD_ACT = `DSPI_ENC_ACT,
      DSPI_CMD_WR = `DSPI_ENC_WR,
      DSPI_CMD_RD = `DSPI_ENC_RD,
      DSPI_CMD_ZQ = `DSPI_ENC_ZQ,
      DSPI_CMD_NOP = `DSPI_ENC_NOP
   } dspi_cmd_type;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_CMD = 3'h1,
      ST_WPRE = 3'h3,
      ST_WRISE = 3'h2,
      ST_WDATA1 = 3'h6,
      ST_WFALL = 3'h7
   } dspi_state_type;
endpackage

/* dspi_sync2.sv */
// Two-stage synchroniser with asynchronous clear
`timescale 1ns/1ps
module dspi_sync2 #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Level in and out
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_q <= '0;
         q_o <= '0;
      end else begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end
endmodule // dspi_sync2

/* dspi_capture_lane.sv */
// Read capture of one byte lane on its returned strobe
`timescale 1ns/1ps
module dspi_capture_lane (
   // Strobe domain
   input wire logic strobe_clk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] dq_i,
   // Captured pair, fall beat high
   output logic [15:0] pair_o,
   output logic toggle_o
);
   logic [7:0] rise_q;
   logic [7:0] fall_q;

   // Rising strobe edge carries the first beat
   always_ff @(posedge strobe_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rise_q <= 8'h00;
      end else begin
         rise_q <= dq_i;
      end
   end

   // Falling edge closes the pair and flags it
   always_ff @(negedge strobe_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fall_q <= 8'h00;
         toggle_o <= 1'b0;
      end else begin
         fall_q <= dq_i;
         toggle_o <= ~toggle_o;
      end
   end

   assign pair_o = {fall_q, rise_q};
endmodule // dspi_capture_lane

/* dspi_pin_if.sv */
// DDR3 SDRAM pin interface, device side
// Operation
// [RL1] Drive 16-bit address: row on activate, column on read and write.
// [RL2] Drive 3-bit bank select for activate, read, write, precharge.
// [RL3] Drive differential memory clock, true and complement in opposite phase.
// [RL4] Clock enable low stops memory clock, high enables it.
// [RL5] Two active-low chip selects; only the selected rank takes a command.
// [RL6] Low mask covers data bits 7:0, high mask bits 15:8.
// [RL7] Sender drives the data strobes; device drives them during writes.
// [RL8] Memory returns edge-aligned strobes on reads; device captures with them.
// [RL9] Low strobe times data bits 7:0, high strobe bits 15:8.
// [RL10] Row, column, write-enable strobes plus chip select encode each command.
// [RL11] Drive two on-die termination control outputs.
// [RL12] Drive data and strobes only while writing; release them otherwise.
// [RL13] Command encodings follow the DDR3 command truth table.
`timescale 1ns/1ps
`include "dspi_map.svh"
module dspi_pin_if
   import dspi_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Command request
   input wire logic cmd_valid_i,
   output logic cmd_ready_o,
   input wire dspi_cmd_type cmd_code_i,
   input wire logic cmd_rank_i,
   input wire logic [2:0] cmd_bank_i,
   input wire logic [15:0] cmd_addr_i,
   // Write data
   input wire logic [31:0] wr_data_i,
   input wire logic [3:0] wr_mask_i,
   // Read data
   output logic rd_valid_o,
   output logic [31:0] rd_data_o,
   // Static controls
   input wire logic cke_i,
   input wire logic [1:0] odt_i,
   // Memory command pins
   output logic [15:0] mem_addr_o,
   output logic [2:0] mem_bank_o,
   output logic mem_clk_true_o,
   output logic mem_clk_comp_o,
   output logic mem_clk_enable_o,
   output logic [1:0] mem_chip_select_n_o,
   output logic row_strobe_n_o,
   output logic column_strobe_n_o,
   output logic write_enable_n_o,
   output logic [1:0] mem_termination_ctrl_o,
   output logic low_byte_write_mask_o,
   output logic high_byte_write_mask_o,
   // Data bus
   input wire logic [15:0] mem_data_i,
   output logic [15:0] mem_data_o,
   output logic mem_data_oe_o,
   // Data strobes
   input wire logic low_byte_strobe_p_i,
   output logic low_byte_strobe_p_o,
   output logic low_byte_strobe_p_oe_o,
   input wire logic low_byte_strobe_n_i,
   output logic low_byte_strobe_n_o,
   output logic low_byte_strobe_n_oe_o,
   input wire logic high_byte_strobe_p_i,
   output logic high_byte_strobe_p_o,
   output logic high_byte_strobe_p_oe_o,
   input wire logic high_byte_strobe_n_i,
   output logic high_byte_strobe_n_o,
   output logic high_byte_strobe_n_oe_o
);
   // ****************************************
   // Reset release
   // ****************************************
   logic rst_n_q;

   dspi_sync2 #(.W(1)) u_rst_sync (
      .clk_i(clk_i),
      .rst_n_i(resetn_i),
      .d_i(1'b1),
      .q_o(rst_n_q)
   );

   // ****************************************
   // Memory clock and command sequencer
   // ****************************************
   dspi_state_type st_q;
   dspi_state_type st_d;
   logic accept;
   logic is_wr_q;
   logic [31:0] wdata_q;
   logic [3:0] wmask_q;
   logic rd_pend_q;

   assign accept = cmd_valid_i && cmd_ready_o;

   // Divide by two; commands change while the clock is falling
   always_ff @(posedge clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         mem_clk_true_o <= 1'b0;
         mem_clk_comp_o <= 1'b1;
      end else begin
         mem_clk_true_o <= ~mem_clk_true_o; // RL3
         mem_clk_comp_o <= mem_clk_true_o; // RL3
      end
   end

   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_IDLE: begin
            if (accept) begin
               st_d = ST_CMD;
            end
         end
         // Command stands a full memory clock: leave when the clock is high
         ST_CMD: begin
            if (mem_clk_true_o) begin
               st_d = is_wr_q ? ST_WPRE : ST_IDLE;
            end
         end
         ST_WPRE: st_d = ST_WRISE;
         ST_WRISE: st_d = ST_WDATA1;
         ST_WDATA1: st_d = ST_WFALL;
         ST_WFALL: st_d = ST_IDLE;
         default: st_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         st_q <= ST_IDLE;
         cmd_ready_o <= 1'b0;
      end else begin
         st_q <= st_d;
         // Ready only when the next edge lowers the memory clock
         cmd_ready_o <= (st_d == ST_IDLE) && !mem_clk_true_o;
      end
   end

   // Command pins: held one full memory clock, NOP otherwise
   always_ff @(posedge clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         {row_strobe_n_o, column_strobe_n_o, write_enable_n_o} <= `DSPI_ENC_NOP;
         mem_chip_select_n_o <= `DSPI_CS_IDLE;
         mem_addr_o <= `DSPI_ADDR_RST;
         mem_bank_o <= `DSPI_BANK_RST;
         is_wr_q <= 1'b0;
      end else if (accept) begin
         {row_strobe_n_o, column_strobe_n_o, write_enable_n_o} <= cmd_code_i; // RL10 RL13
         mem_chip_select_n_o <= `DSPI_CS_IDLE;
         mem_chip_select_n_o[cmd_rank_i] <= 1'b0; // RL5
         mem_addr_o <= cmd_addr_i; // RL1
         mem_bank_o <= cmd_bank_i; // RL2
         is_wr_q <= (cmd_code_i == DSPI_CMD_WR);
      end else if ((st_q == ST_CMD) && mem_clk_true_o) begin
         {row_strobe_n_o, column_strobe_n_o, write_enable_n_o} <= `DSPI_ENC_NOP;
         mem_chip_select_n_o <= `DSPI_CS_IDLE; // RL5
      end
   end

   // Static controls
   always_ff @(posedge clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         mem_clk_enable_o <= `DSPI_CKE_RST;
         mem_termination_ctrl_o <= `DSPI_ODT_RST;
      end else begin
         mem_clk_enable_o <= cke_i; // RL4
         mem_termination_ctrl_o <= odt_i; // RL11
      end
   end

   // ****************************************
   // Write burst: data and strobes
   // ****************************************
   logic drive_d;
   logic dqs_d;

   assign drive_d = (st_d == ST_WPRE) || (st_d == ST_WRISE) ||
                    (st_d == ST_WDATA1) || (st_d == ST_WFALL);
   assign dqs_d = (st_d == ST_WRISE) || (st_d == ST_WDATA1);

   always_ff @(posedge clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         wdata_q <= `DSPI_WORD_RST;
         wmask_q <= `DSPI_MASK_RST;
      end else if (accept) begin
         wdata_q <= wr_data_i;
         wmask_q <= wr_mask_i;
      end
   end

   // Data changes one clk_i cycle, half a memory clock, before each strobe edge
   always_ff @(posedge clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         mem_data_o <= `DSPI_DQ_RST;
         {high_byte_write_mask_o, low_byte_write_mask_o} <= 2'h0;
      end else if (st_d == ST_WPRE) begin
         mem_data_o <= wdata_q[`DSPI_BEAT0];
         {high_byte_write_mask_o, low_byte_write_mask_o} <= wmask_q[`DSPI_MASK0]; // RL6
      end else if (st_d == ST_WDATA1) begin
         mem_data_o <= wdata_q[`DSPI_BEAT1];
         {high_byte_write_mask_o, low_byte_write_mask_o} <= wmask_q[`DSPI_MASK1]; // RL6
      end
   end

   // Released outside writes so the memory can return data
   always_ff @(posedge clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         mem_data_oe_o <= 1'b0;
         {low_byte_strobe_p_oe_o, low_byte_strobe_n_oe_o} <= 2'h0;
         {high_byte_strobe_p_oe_o, high_byte_strobe_n_oe_o} <= 2'h0;
         low_byte_strobe_p_o <= 1'b0;
         low_byte_strobe_n_o <= 1'b1;
         high_byte_strobe_p_o <= 1'b0;
         high_byte_strobe_n_o <= 1'b1;
      end else begin
         mem_data_oe_o <= drive_d; // RL12
         {low_byte_strobe_p_oe_o, low_byte_strobe_n_oe_o} <= {2{drive_d}}; // RL7
         {high_byte_strobe_p_oe_o, high_byte_strobe_n_oe_o} <= {2{drive_d}}; // RL7
         low_byte_strobe_p_o <= dqs_d; // RL9
         low_byte_strobe_n_o <= ~dqs_d;
         high_byte_strobe_p_o <= dqs_d; // RL9
         high_byte_strobe_n_o <= ~dqs_d;
      end
   end

   // ****************************************
   // Read capture across the strobe domains
   // ****************************************
   logic [15:0] lo_pair;
   logic [15:0] hi_pair;
   logic [1:0] tog_raw;
   logic [1:0] tog_s;
   logic [1:0] tog_seen_q;
   logic [1:0] got_q;
   logic [1:0] edge_s;
   logic emit;

   dspi_capture_lane u_lo_lane (
      .strobe_clk_i(low_byte_strobe_p_i),
      .rst_n_i(rst_n_q),
      .dq_i(mem_data_i[`DSPI_LO]),
      .pair_o(lo_pair),
      .toggle_o(tog_raw[0])
   ); // RL8 RL9

   dspi_capture_lane u_hi_lane (
      .strobe_clk_i(high_byte_strobe_p_i),
      .rst_n_i(rst_n_q),
      .dq_i(mem_data_i[`DSPI_HI]),
      .pair_o(hi_pair),
      .toggle_o(tog_raw[1])
   ); // RL8 RL9

   dspi_sync2 #(.W(2)) u_tog_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_q),
      .d_i(tog_raw),
      .q_o(tog_s)
   );

   assign edge_s = tog_s ^ tog_seen_q;
   assign emit = &got_q;

   // Pairs seen without a pending read are own write strobes
   always_ff @(posedge clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         tog_seen_q <= 2'h0;
         got_q <= 2'h0;
         rd_pend_q <= 1'b0;
      end else begin
         tog_seen_q <= tog_s;
         got_q <= rd_pend_q ? ((got_q & ~{2{emit}}) | edge_s) : 2'h0;
         rd_pend_q <= (rd_pend_q && !emit) || (accept && cmd_code_i == DSPI_CMD_RD);
      end
   end

   // Lane pairs are stable: the strobe stands still once it is synced
   always_ff @(posedge clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rd_valid_o <= 1'b0;
         rd_data_o <= `DSPI_WORD_RST;
      end else begin
         rd_valid_o <= emit; // RL8
         if (emit) begin
            rd_data_o <= {hi_pair[`DSPI_HI], lo_pair[`DSPI_HI],
                          hi_pair[`DSPI_LO], lo_pair[`DSPI_LO]}; // RL9
         end
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   logic [2:0] cmd_pins;

   assign cmd_pins = {row_strobe_n_o, column_strobe_n_o, write_enable_n_o};

   property p_clk_pair;
      @(posedge clk_i) disable iff (!rst_n_q)
      mem_clk_true_o |=> !mem_clk_true_o && mem_clk_comp_o ##1 mem_clk_true_o;
   endproperty
   a_clk_pair: assert property (p_clk_pair) else $error("memory clock pair wrong"); // RL3

   property p_cmd_hold;
      @(posedge clk_i) disable iff (!rst_n_q)
      $changed(cmd_pins) |-> !mem_clk_true_o ##1 $stable(cmd_pins);
   endproperty
   a_cmd_hold: assert property (p_cmd_hold) else $error("command not held"); // RL10

   property p_addr_hold;
      @(posedge clk_i) disable iff (!rst_n_q)
      $rose(mem_clk_true_o) |-> $stable(mem_addr_o);
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address moved at edge"); // RL1

   property p_bank_cmd;
      @(posedge clk_i) disable iff (!rst_n_q)
      accept |=> mem_bank_o == $past(cmd_bank_i) ##1 $stable(mem_bank_o);
   endproperty
   a_bank_cmd: assert property (p_bank_cmd) else $error("bank not driven"); // RL2

   property p_cs_cmd;
      @(posedge clk_i) disable iff (!rst_n_q)
      (cmd_pins != `DSPI_ENC_NOP) |-> $onehot(~mem_chip_select_n_o);
   endproperty
   a_cs_cmd: assert property (p_cs_cmd) else $error("chip select wrong"); // RL5

   property p_cke;
      @(posedge clk_i) disable iff (!rst_n_q)
      ##1 mem_clk_enable_o == $past(cke_i);
   endproperty
   a_cke: assert property (p_cke) else $error("clock enable lags"); // RL4

   property p_odt;
      @(posedge clk_i) disable iff (!rst_n_q)
      $changed(odt_i) |=> mem_termination_ctrl_o == $past(odt_i);
   endproperty
   a_odt: assert property (p_odt) else $error("termination not driven"); // RL11

   property p_wr_strobe;
      @(posedge clk_i) disable iff (!rst_n_q)
      $rose(mem_data_oe_o) |-> !low_byte_strobe_p_o && high_byte_strobe_p_oe_o
         ##1 low_byte_strobe_p_o ##1 high_byte_strobe_p_o ##1 !low_byte_strobe_p_o
         ##1 !mem_data_oe_o && !low_byte_strobe_p_oe_o;
   endproperty
   a_wr_strobe: assert property (p_wr_strobe) else $error("write strobe wrong"); // RL7

   property p_wr_mask;
      @(posedge clk_i) disable iff (!rst_n_q)
      $rose(mem_data_oe_o) |->
         {high_byte_write_mask_o, low_byte_write_mask_o} == wmask_q[`DSPI_MASK0]
         ##2 {high_byte_write_mask_o, low_byte_write_mask_o} == wmask_q[`DSPI_MASK1];
   endproperty
   a_wr_mask: assert property (p_wr_mask) else $error("write mask wrong"); // RL6

   property p_oe_write;
      @(posedge clk_i) disable iff (!rst_n_q)
      mem_data_oe_o == (st_q inside {ST_WPRE, ST_WRISE, ST_WDATA1, ST_WFALL});
   endproperty
   a_oe_write: assert property (p_oe_write) else $error("bus driven outside write"); // RL12

   property p_rd_pulse;
      @(posedge clk_i) disable iff (!rst_n_q)
      rd_valid_o |-> $past(rd_pend_q) ##1 !rd_valid_o;
   endproperty
   a_rd_pulse: assert property (p_rd_pulse) else $error("read answer wrong"); // RL8

   property p_enc_wr;
      @(posedge clk_i) disable iff (!rst_n_q)
      accept && cmd_code_i == DSPI_CMD_WR |=> cmd_pins == `DSPI_ENC_WR ##2 st_q == ST_WPRE;
   endproperty
   a_enc_wr: assert property (p_enc_wr) else $error("write encoding wrong"); // RL13

   c_write: cover property (@(posedge clk_i) disable iff (!rst_n_q) st_q == ST_WFALL);
   c_read: cover property (@(posedge clk_i) disable iff (!rst_n_q) rd_valid_o);
   c_refresh: cover property (@(posedge clk_i) disable iff (!rst_n_q)
      accept && cmd_code_i == DSPI_CMD_REF);
endmodule // dspi_pin_if

/* dspi_mem_model.sv */
// Memory-side partner model of the DDR3 pin interface
`timescale 1ns/1ps
module dspi_mem_model #(
   parameter logic [31:0] INIT = 32'h0000_0000
) (
   // Command pins
   input wire logic clk_i,
   input wire logic [1:0] cs_n_i,
   input wire logic [2:0] cmd_i,
   // Write side, device-driven
   input wire logic [15:0] dq_i,
   input wire logic dq_oe_i,
   input wire logic [1:0] strobe_i,
   input wire logic [1:0] mask_i,
   // Answer speed
   input wire logic slow_i,
   // Read side
   output logic [15:0] dq_o,
   output logic strobe_o
);
   // ****************************
   // Write capture and read return
   // ****************************
   logic [31:0] store = INIT;
   event go;

   initial begin
      dq_o = 16'h5a5a;
      strobe_o = 1'b0;
   end

   // Lane capture on the device strobe, masked bytes kept
   always @(posedge strobe_i[0]) if (dq_oe_i && !mask_i[0]) store[7:0] = dq_i[7:0];
   always @(posedge strobe_i[1]) if (dq_oe_i && !mask_i[1]) store[15:8] = dq_i[15:8];
   always @(negedge strobe_i[0]) if (dq_oe_i && !mask_i[0]) store[23:16] = dq_i[7:0];
   always @(negedge strobe_i[1]) if (dq_oe_i && !mask_i[1]) store[31:24] = dq_i[15:8];

   // Released bus shows the inverse of its last value
   always @(negedge dq_oe_i) dq_o = ~dq_i;

   // Only a selected rank takes a read
   always @(posedge clk_i) if (cs_n_i != 2'h3 && cmd_i == 3'h5) -> go;

   // Edge-aligned burst, strobe parked low outside it
   initial forever begin
      @go;
      #(150 + 250 * slow_i);
      dq_o = store[15:0];
      #40 strobe_o = 1'b1;
      #5 dq_o = store[31:16];
      #57.5 strobe_o = 1'b0;
      #5 dq_o = ~dq_o;
   end
endmodule // dspi_mem_model

/* test_dspi_pin_if.sv */
// Self-checking testbench of the DDR3 pin interface
`timescale 1ns/1ps
module test_dspi_pin_if import dspi_pkg::*; ;
   // ****************************
   // Stimulus, wires and instances
   // ****************************
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic cmd_valid_i = 1'b0;
   logic cmd_rank_i = 1'b0;
   logic cke_i = 1'b0;
   logic slow = 1'b0;
   dspi_cmd_type cmd_code_i = DSPI_CMD_NOP;
   logic [2:0] cmd_bank_i = 3'h0;
   logic [15:0] cmd_addr_i = 16'h0000;
   logic [31:0] wr_data_i = 32'h0000_0000;
   logic [3:0] wr_mask_i = 4'h0;
   logic [1:0] odt_i = 2'h0;
   logic cmd_ready_o, rd_valid_o, ck_t, ck_c, cke_o, ras_n, cas_n, we_n, lmask, hmask, dq_oe, m_strb;
   logic [31:0] rd_data_o;
   logic [15:0] addr_o, dq_o, m_dq, dq_i;
   logic [2:0] bank_o;
   logic [1:0] cs_n, odt_o;
   logic [3:0] s_o, s_oe, s_i;
   int num_errors = 0;
   int n_checks = 0;
   int cycles = 0;

   // Wire levels from the device's enables, memory otherwise; strobe order {hi_n, hi_p, lo_n, lo_p}
   assign dq_i = dq_oe ? dq_o : m_dq;
   assign s_i = (s_oe & s_o) | (~s_oe & {~m_strb, m_strb, ~m_strb, m_strb});

   always #12.5 clk_i = ~clk_i;

   dspi_pin_if i_dut (
      .clk_i(clk_i), .resetn_i(resetn_i),
      .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_code_i(cmd_code_i),
      .cmd_rank_i(cmd_rank_i), .cmd_bank_i(cmd_bank_i), .cmd_addr_i(cmd_addr_i),
      .wr_data_i(wr_data_i), .wr_mask_i(wr_mask_i),
      .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
      .cke_i(cke_i), .odt_i(odt_i),
      .mem_addr_o(addr_o), .mem_bank_o(bank_o),
      .mem_clk_true_o(ck_t), .mem_clk_comp_o(ck_c), .mem_clk_enable_o(cke_o),
      .mem_chip_select_n_o(cs_n), .row_strobe_n_o(ras_n), .column_strobe_n_o(cas_n),
      .write_enable_n_o(we_n), .mem_termination_ctrl_o(odt_o),
      .low_byte_write_mask_o(lmask), .high_byte_write_mask_o(hmask),
      .mem_data_i(dq_i), .mem_data_o(dq_o), .mem_data_oe_o(dq_oe),
      .low_byte_strobe_p_i(s_i[0]), .low_byte_strobe_p_o(s_o[0]),
      .low_byte_strobe_p_oe_o(s_oe[0]),
      .low_byte_strobe_n_i(s_i[1]), .low_byte_strobe_n_o(s_o[1]),
      .low_byte_strobe_n_oe_o(s_oe[1]),
      .high_byte_strobe_p_i(s_i[2]), .high_byte_strobe_p_o(s_o[2]),
      .high_byte_strobe_p_oe_o(s_oe[2]),
      .high_byte_strobe_n_i(s_i[3]), .high_byte_strobe_n_o(s_o[3]),
      .high_byte_strobe_n_oe_o(s_oe[3])
   );

   dspi_mem_model i_mem (
      .clk_i(clk_i), .cs_n_i(cs_n), .cmd_i({ras_n, cas_n, we_n}),
      .dq_i(dq_o), .dq_oe_i(dq_oe), .strobe_i({s_i[2], s_i[0]}), .mask_i({hmask, lmask}),
      .slow_i(slow), .dq_o(m_dq), .strobe_o(m_strb)
   );

   // ****************************
   // Checking and closing
   // ****************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         tally_and_finish();
      end
   end

   always @(negedge clk_i) if (resetn_i) check(ck_c, {~ck_t}, "clock pair");

   // ****************************
   // Scenarios
   // ****************************
   // Issue one command; returns in the cycle after it stood
   task automatic issue(input dspi_cmd_type c, input logic r, input logic [2:0] b,
                        input logic [15:0] a);
      int n;
      n = 0;
      cmd_code_i = c;
      cmd_rank_i = r;
      cmd_bank_i = b;
      cmd_addr_i = a;
      cmd_valid_i = 1'b1;
      while (cmd_ready_o !== 1'b1 && n < 20) begin
         @(negedge clk_i);
         n++;
      end
      check(n < 20, 1, "ready");
      @(negedge clk_i);
      cmd_valid_i = 1'b0;
      check({cs_n, ras_n, cas_n, we_n}, {~(2'h1 << r), c}, "command");
      check({bank_o, addr_o}, {b, a}, "address");
      check({ck_t, ck_c}, 2'b01, "clock low");
      @(negedge clk_i);
      check({cs_n, ras_n, cas_n, we_n, ck_t, ck_c}, {~(2'h1 << r), c, 2'b10}, "held");
      @(negedge clk_i);
      check({cs_n, ras_n, cas_n, we_n, addr_o}, {2'h3, 3'h7, a}, "idle");
   endtask

   task automatic statics();
      cke_i = 1'b1;
      odt_i = 2'h1;
      @(negedge clk_i);
      check({cke_o, odt_o}, 3'b101, "static a");
      cke_i = 1'b0;
      odt_i = 2'h2;
      @(negedge clk_i);
      check({cke_o, odt_o}, 3'b010, "static b");
      cke_i = 1'b1;
   endtask

   task automatic cmd_loop();
      for (int i = 0; i < 8; i++) begin
         issue(dspi_cmd_type'(i[2:0]), i[0], 3'(7 - i), 16'h8000 >> i);
      end
      repeat (20) @(negedge clk_i);
   endtask

   task automatic wr(input logic [31:0] d, input logic [3:0] m);
      wr_data_i = d;
      wr_mask_i = m;
      issue(DSPI_CMD_WR, 1'b0, 3'h2, 16'h0010);
      check({dq_oe, s_oe, s_o, dq_o, hmask, lmask}, {5'h1f, 4'b1010, d[15:0], m[1:0]}, "beat0");
      @(negedge clk_i);
      check(s_o, 4'b0101, "strobe rise");
      @(negedge clk_i);
      check({dq_o, hmask, lmask}, {d[31:16], m[3:2]}, "beat1");
      @(negedge clk_i);
      check(s_o, 4'b1010, "strobe fall");
      @(negedge clk_i);
      check({dq_oe, s_oe}, 5'h00, "release");
   endtask

   task automatic rd(input logic sl, input logic [31:0] exp);
      int n;
      n = 0;
      slow = sl;
      issue(DSPI_CMD_RD, 1'b1, 3'h5, 16'h0040);
      check({dq_oe, s_oe}, 5'h00, "read float");
      while (rd_valid_o !== 1'b1 && n < 60) begin
         @(negedge clk_i);
         n++;
      end
      check(n < 60, 1, "read answer");
      check(rd_data_o, exp, "read data");
   endtask

   initial begin
      repeat (10) @(negedge clk_i);
      check({ck_t, ck_c, cke_o, odt_o, cs_n, ras_n, cas_n, we_n, dq_oe, s_oe, s_o,
             rd_valid_o, cmd_ready_o}, {2'b01, 1'b0, 2'h0, 2'h3, 3'h7, 5'h00, 4'b1010, 2'b00},
            "reset");
      repeat (10) @(negedge clk_i);
      resetn_i = 1'b1;
      repeat (4) @(negedge clk_i);
      statics();
      cmd_loop();
      wr(32'hc3a5_5a3c, 4'h0);
      wr(32'h0ff0_e11e, 4'h9);
      rd(1'b0, 32'hc3f0_e13c);
      rd(1'b1, 32'hc3f0_e13c);
      tally_and_finish();
   end
endmodule // test_dspi_pin_if
